// *** svda_top.sv ***
// Shared DRAM slot timing, display address path and byte serialiser
`timescale 1ns/1ps
module svda_top (
    input  wire logic                     clk,
    input  wire logic                     reset,
    input  wire logic [15:0]              cpu_addr,
    input  wire logic                     two_banks,
    input  wire logic [13:0]              crtc_ma,
    input  wire logic [2:0]               crtc_ra,
    input  wire logic                     offset_select_low,
    input  wire logic                     offset_select_high,
    input  wire svda_pkg::svda_pix_mode_t pix_mode,
    input  wire logic [7:0]               ram_data,
    output logic [6:0]                    ram_addr,
    output logic                          ras_n,
    output logic                          cas_lo_n,
    output logic                          cas_hi_n,
    output logic                          cpu_slot,
    output logic                          cpu_ram_sel,
    output logic                          text_mode,
    output logic [7:0]                    char_code,
    output logic                          char_strobe,
    output logic [3:0]                    pix_bits,
    output logic                          pix_valid,
    input  wire logic                     pix_ready,
    output logic                          crtc_stall,
    output logic                          clk8,
    output logic                          clk4,
    output logic                          clk2,
    output logic                          char_clk
);
    import svda_pkg::*;

    svda_state_t st;
    svda_state_t next_st;

    logic [3:0]  off4;
    logic [3:0]  adj_top;
    logic [14:0] bm_addr;
    logic [14:0] tx_addr;
    logic [14:0] disp_addr;
    logic [14:0] slot_addr;
    logic [6:0]  row_half;
    logic [6:0]  col_half;
    logic        bank_bit;
    logic        slot_end;
    logic        access;
    logic        buf_in_valid;
    logic        buf_in_ready;
    logic        buf_out_valid;
    logic        buf_out_ready;
    logic [7:0]  buf_out_data;
    logic        fire;
    logic [3:0]  rem;
    logic [3:0]  sh;
    logic [3:0]  load_cnt;

    // Offset in 2 Kbyte blocks, gated by the wrap bit
    always_comb begin
        unique case ({offset_select_high, offset_select_low})
            2'b00:   off4 = 4'(BYTE_OFF_16K >> BLK_SH);
            2'b01:   off4 = 4'(BYTE_OFF_8K >> BLK_SH);
            2'b10:   off4 = 4'(BYTE_OFF_20K >> BLK_SH);
            default: off4 = 4'(BYTE_OFF_10K >> BLK_SH);
        endcase
    end

    // Four-bit add wraps the 14-line space inside 32 Kbytes
    assign adj_top = crtc_ma[11:8] + (crtc_ma[12] ? off4 : 4'h0);
    // Cell-ordered layout; row half walks ma[3:0] and ra, so refresh
    // needs no extra cycles
    assign bm_addr = {adj_top, crtc_ma[7:0], crtc_ra};
    assign tx_addr = {TEXT_BANK, TEXT_TOP, crtc_ma[9:0]};
    assign text_mode = crtc_ma[13];
    assign disp_addr = text_mode ? tx_addr : bm_addr;
    assign cpu_ram_sel = !cpu_addr[15];

    assign slot_end = (st.phase == SLOT_LAST);
    assign buf_in_valid = slot_end && !st.cpu_slot && !text_mode;
    // Bitmap byte waits in the buffer; stall flags a full buffer
    assign crtc_stall = !buf_in_ready;

    svda_buf #(
        .W     (8),
        .DEPTH (2)
    ) u_buf (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (ram_data),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_out_data)
    );

    always_comb begin
        unique case (pix_mode)
            PIX_1: begin
                sh       = 4'h1;
                load_cnt = CNT_1BPP;
                pix_bits = {3'h0, st.shreg[7]};
            end
            PIX_2: begin
                sh       = 4'h2;
                load_cnt = CNT_2BPP;
                pix_bits = {2'h0, st.shreg[7:6]};
            end
            PIX_4: begin
                sh       = 4'h4;
                load_cnt = CNT_4BPP;
                pix_bits = st.shreg[7:4];
            end
            default: begin
                sh       = 4'h1;
                load_cnt = CNT_1BPP;
                pix_bits = {3'h0, st.shreg[7]};
            end
        endcase
    end

    assign pix_valid = (st.shcnt != 4'h0);
    assign fire = pix_valid && pix_ready;
    assign rem = fire ? st.shcnt - 4'h1 : st.shcnt;
    assign buf_out_ready = (rem == 4'h0);

    always_comb begin
        next_st = st;
        next_st.char_strobe = 1'b0;
        next_st.phase = slot_end ? 5'h00 : st.phase + 5'h01;
        if (slot_end) begin
            next_st.cpu_slot = !st.cpu_slot;
        end
        // Slot timing waves; clk2 follows slot ownership
        next_st.clk4 = (next_st.phase < QTR_2);
        next_st.clk8 = (next_st.phase < QTR_1) ||
                       ((next_st.phase >= QTR_2) && (next_st.phase < QTR_3));
        next_st.clk2 = next_st.cpu_slot;
        // RAS taken from the 8/4 waveforms, common to all devices
        if (next_st.clk8 && !st.clk8) begin
            next_st.ras_n = 1'b1;
        end else if (next_st.phase == RAS_PH) begin
            next_st.ras_n = 1'b0;
        end
        // Set or reset on each 8 MHz rise by 4 MHz level
        if (next_st.clk8 && !st.clk8) begin
            next_st.char_sr = next_st.clk4;
        end
        next_st.char_clk = st.char_sr ^ st.clk2;
        next_st.ram_addr = (next_st.phase >= COL_PH) ? col_half
                                                     : row_half;
        next_st.cas_lo_n = 1'b1;
        next_st.cas_hi_n = 1'b1;
        if ((next_st.phase >= CAS_PH) && access) begin
            if (two_banks && !bank_bit) begin
                next_st.cas_lo_n = 1'b0;
            end else begin
                next_st.cas_hi_n = 1'b0;
            end
        end
        if (slot_end && !st.cpu_slot && text_mode) begin
            next_st.char_code   = ram_data;
            next_st.char_strobe = 1'b1;
        end
        if (fire) begin
            next_st.shreg = st.shreg << sh;
            next_st.shcnt = rem;
        end
        if (buf_out_ready && buf_out_valid) begin
            next_st.shreg = buf_out_data;
            next_st.shcnt = load_cnt;
        end
    end

    // Address source follows the slot that the next cycle belongs to
    always_comb begin
        slot_addr = next_st.cpu_slot ? cpu_addr[14:0] : disp_addr;
        row_half  = slot_addr[6:0];
        col_half  = slot_addr[13:7];
        bank_bit  = slot_addr[14];
        access    = next_st.cpu_slot ? cpu_ram_sel : 1'b1;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st          <= '0;
            st.ras_n    <= 1'b1;
            st.cas_lo_n <= 1'b1;
            st.cas_hi_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign ram_addr    = st.ram_addr;
    assign ras_n       = st.ras_n;
    assign cas_lo_n    = st.cas_lo_n;
    assign cas_hi_n    = st.cas_hi_n;
    assign cpu_slot    = st.cpu_slot;
    assign char_code   = st.char_code;
    assign char_strobe = st.char_strobe;
    assign clk8        = st.clk8;
    assign clk4        = st.clk4;
    assign clk2        = st.clk2;
    assign char_clk    = st.char_clk;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_slot_end;
        st.phase == SLOT_LAST;
    endsequence

    sequence s_row_open;
        (st.phase == RAS_PH) ##0 !ras_n;
    endsequence

    property p_slot_swap;
        s_slot_end |=> (cpu_slot != $past(cpu_slot)) && (st.phase == 5'h00);
    endproperty
    a_slot_swap: assert property (p_slot_swap)
        else $error("slot owner did not swap at slot end");

    property p_slot_only_at_end;
        $changed(cpu_slot) |-> (st.phase == 5'h00);
    endproperty
    a_slot_only_at_end: assert property (p_slot_only_at_end)
        else $error("slot owner changed mid slot");

    property p_row_then_col;
        s_row_open ##0 (ram_addr == $past(row_half))
            |-> ##(COL_PH - RAS_PH) (ram_addr == $past(col_half));
    endproperty
    a_row_then_col: assert property (p_row_then_col)
        else $error("row/column halves out of order");

    property p_ras_precharge;
        (st.phase < RAS_PH) |-> ras_n;
    endproperty
    a_ras_precharge: assert property (p_ras_precharge)
        else $error("row strobe low during precharge");

    property p_low_bank;
        !cas_lo_n |-> two_banks && !$past(bank_bit);
    endproperty
    a_low_bank: assert property (p_low_bank)
        else $error("lower bank strobe for upper address");

    property p_no_wrap;
        (!crtc_ma[12] && !text_mode) |-> (disp_addr[14:11] == crtc_ma[11:8]);
    endproperty
    a_no_wrap: assert property (p_no_wrap)
        else $error("offset added without wrap bit");

    property p_text_top;
        text_mode |-> (disp_addr[13:10] == TEXT_TOP) &&
                      (disp_addr[9:0] == crtc_ma[9:0]);
    endproperty
    a_text_top: assert property (p_text_top)
        else $error("text mode top lines not forced high");

    property p_rom_no_cas;
        (cpu_slot && (st.phase > CAS_PH) && $past(cpu_addr[15]))
            |-> cas_lo_n && cas_hi_n;
    endproperty
    a_rom_no_cas: assert property (p_rom_no_cas)
        else $error("column strobe for non-RAM address");

    property p_char_latch;
        s_slot_end ##0 (!cpu_slot && text_mode)
            |=> char_strobe && (char_code == $past(ram_data));
    endproperty
    a_char_latch: assert property (p_char_latch)
        else $error("text byte not latched at slot end");

    property p_pix_count;
        (pix_mode == PIX_4) && $rose(pix_valid) && pix_ready
            |=> pix_valid;
    endproperty
    a_pix_count: assert property (p_pix_count)
        else $error("4-bit stream ended after one pixel");

    property p_ras_open;
        (st.phase >= RAS_PH) && (st.phase < QTR_2) |-> !ras_n;
    endproperty
    a_ras_open: assert property (p_ras_open)
        else $error("row strobe high inside row window");

    property p_ras_close;
        (st.phase >= QTR_2) |-> ras_n;
    endproperty
    a_ras_close: assert property (p_ras_close)
        else $error("row strobe low after second 8 MHz rise");

    // Reset state is not a slot phase, so skip the first edge
    property p_clk4_wave;
        !$past(reset) |-> (clk4 == (st.phase < QTR_2)) &&
                          (clk2 == cpu_slot);
    endproperty
    a_clk4_wave: assert property (p_clk4_wave)
        else $error("4 or 2 MHz wave out of step with slot");

    property p_clk8_wave;
        !$past(reset) |-> (clk8 == ((st.phase < QTR_1) ||
            ((st.phase >= QTR_2) && (st.phase < QTR_3))));
    endproperty
    a_clk8_wave: assert property (p_clk8_wave)
        else $error("8 MHz wave out of step with slot");

    property p_char_clk;
        1'b1 |=> (char_clk == ($past(clk4) ^ $past(clk2)));
    endproperty
    a_char_clk: assert property (p_char_clk)
        else $error("character clock not flip-flop xor 2 MHz");

    property p_row_window;
        !$past(reset) && (st.phase < COL_PH)
            |-> (ram_addr == $past(row_half));
    endproperty
    a_row_window: assert property (p_row_window)
        else $error("row half missing before column phase");

    property p_col_window;
        (st.phase >= COL_PH) |-> (ram_addr == $past(col_half));
    endproperty
    a_col_window: assert property (p_col_window)
        else $error("column half missing after column phase");

    property p_cas_closed;
        (st.phase < CAS_PH) |-> cas_lo_n && cas_hi_n;
    endproperty
    a_cas_closed: assert property (p_cas_closed)
        else $error("column strobe before column phase");

    property p_disp_access;
        !cpu_slot && (st.phase >= CAS_PH) |-> !(cas_lo_n && cas_hi_n);
    endproperty
    a_disp_access: assert property (p_disp_access)
        else $error("display slot skipped its access");

    property p_one_strobe;
        cas_lo_n || cas_hi_n;
    endproperty
    a_one_strobe: assert property (p_one_strobe)
        else $error("both bank column strobes low");

    property p_one_bank;
        !two_banks |-> cas_lo_n;
    endproperty
    a_one_bank: assert property (p_one_bank)
        else $error("lower bank strobe with one bank fitted");

    property p_byte_load;
        buf_out_valid && (st.shcnt == 4'h0) |=> pix_valid;
    endproperty
    a_byte_load: assert property (p_byte_load)
        else $error("waiting byte not loaded into serialiser");
endmodule

// *** svda_pkg.sv ***
// Constants and types for the shared video DRAM addressing block
// Function
// - Alternate RAM address lines every 250 ns (code: 31-cycle slot, 248 ns at 125 MHz)
// - Row half on RAS, then column half on CAS
// - RAS from flip-flop on 8/4 MHz timing
// - Display address sequence refreshes every row
// - Latch display byte, serialise per display mode
// - Bitmap low bits from character row lines
// - Wrap offset chosen by two offset selects
// - Wrap bit selects zero or gated offset
// - Bitmap column half from display bits 4-7 and offset-adjusted bits 8-10
// - Fourteen display lines wrap in 32 Kbytes
// - Text mode uses ten lines, top forced high
// - Top display bit selects the text path
// - Text bytes latched as character codes
// - Character clock from set/reset flip-flop, XOR
// - Processor bit 15 low selects DRAM
package svda_pkg;
    localparam int          CLK_MHZ   = 125;
    localparam int          SLOT_NS   = 250;
    localparam int          SLOT_CYC  = SLOT_NS * CLK_MHZ / 1000;
    localparam logic [4:0]  SLOT_LAST = 5'(SLOT_CYC - 1);
    localparam logic [4:0]  QTR_1     = 5'(SLOT_CYC / 4);
    localparam logic [4:0]  QTR_2     = 5'(SLOT_CYC / 2);
    localparam logic [4:0]  QTR_3     = 5'(SLOT_CYC * 3 / 4);
    localparam logic [4:0]  RAS_PH    = 5'h02;
    localparam logic [4:0]  COL_PH    = 5'h09;
    localparam logic [4:0]  CAS_PH    = 5'h0c;
    localparam logic [15:0] BYTE_OFF_20K = 16'h3000;
    localparam logic [15:0] BYTE_OFF_16K = 16'h4000;
    localparam logic [15:0] BYTE_OFF_10K = 16'h5800;
    localparam logic [15:0] BYTE_OFF_8K  = 16'h6000;
    localparam int          BLK_SH    = 11;
    localparam logic [3:0]  TEXT_TOP  = 4'hf;
    localparam logic        TEXT_BANK = 1'b1;
    localparam logic [3:0]  CNT_1BPP  = 4'h8;
    localparam logic [3:0]  CNT_2BPP  = 4'h4;
    localparam logic [3:0]  CNT_4BPP  = 4'h2;

    typedef enum logic [1:0] {
        PIX_1 = 2'b00,
        PIX_2 = 2'b01,
        PIX_4 = 2'b10
    } svda_pix_mode_t;

    typedef struct packed {
        logic [4:0] phase;
        logic       cpu_slot;
        logic       ras_n;
        logic       cas_lo_n;
        logic       cas_hi_n;
        logic [6:0] ram_addr;
        logic [7:0] char_code;
        logic       char_strobe;
        logic       clk8;
        logic       clk4;
        logic       clk2;
        logic       char_sr;
        logic       char_clk;
        logic [7:0] shreg;
        logic [3:0] shcnt;
    } svda_state_t;
endpackage

// *** svda_buf.sv ***
// Two-entry valid/ready buffer for display bytes
`timescale 1ns/1ps
module svda_buf #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wptr;
        logic [AW-1:0]           rptr;
        logic [AW:0]             count;
    } svda_buf_t;

    svda_buf_t st;
    svda_buf_t next_st;
    logic      push;
    logic      pop;

    assign in_ready  = (st.count != (AW+1)'(DEPTH));
    assign out_valid = (st.count != '0);
    assign out_data  = st.mem[st.rptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wptr] = in_data;
            next_st.wptr = (st.wptr == AW'(DEPTH - 1)) ? '0 : st.wptr + 1'b1;
        end
        if (pop) begin
            next_st.rptr = (st.rptr == AW'(DEPTH - 1)) ? '0 : st.rptr + 1'b1;
        end
        // Simultaneous push and pop keep the count
        if (push && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_st.count = st.count - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// *** svda_dram_model.sv ***
// Behavioural DRAM partner: latches row then column, returns a pattern byte
`timescale 1ns/1ps
module svda_dram_model (
    input  wire logic [6:0] ram_addr,
    input  wire logic       ras_n,
    input  wire logic       cas_lo_n,
    input  wire logic       cas_hi_n,
    output logic [7:0]      ram_data
);
    logic [6:0]  row;
    logic [14:0] a;

    initial ram_data = 8'h00;

    always @(negedge ras_n) begin
        row = ram_addr;
    end

    // Bank bit taken from which column strobe fired
    always @(negedge cas_lo_n or negedge cas_hi_n) begin
        a = {~cas_hi_n, ram_addr, row};
        #1 ram_data = a[7:0] ^ {a[14:8], 1'b1};
    end

    // Released bus must not keep showing the last byte
    always @(posedge cas_lo_n or posedge cas_hi_n) begin
        if (cas_lo_n && cas_hi_n)
            ram_data = ~ram_data;
    end
endmodule

// *** shared_video_dram_addressing_test.sv ***
// Self-checking bench for the shared video DRAM addressing block
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module shared_video_dram_addressing_test;
    import svda_pkg::*;
    logic clk = 0, reset = 1, two_banks = 0, pix_ready = 1;
    logic offset_select_low = 0, offset_select_high = 0;
    logic [15:0] cpu_addr = 16'h0000;
    logic [13:0] crtc_ma = 14'h0000;
    logic [2:0] crtc_ra = 3'h0;
    svda_pix_mode_t pix_mode = PIX_1;
    logic [7:0] ram_data, char_code, cur;
    logic [6:0] ram_addr, row;
    logic [3:0] pix_bits;
    logic ras_n, cas_lo_n, cas_hi_n, cpu_slot, cpu_ram_sel, text_mode;
    logic char_strobe, pix_valid, crtc_stall, clk8, clk4, clk2, char_clk;
    logic last_ras = 1, last_cas = 1, last_cs = 0, got_cas = 0;
    logic exp_acc = 1, slot_ok = 0, chk_pix = 1, hi;
    logic e8, e4, er, ec, dh;
    logic [14:0] ea, da;
    logic [7:0] q[$];
    logic [31:0] seed = 32'ha16b768e;
    int n_errors = 0, n_checks = 0, cycles = 0, slot_len = 0, npix = 0, w;
    int m, i;

    svda_top i_svda_top (.clk(clk), .reset(reset), .cpu_addr(cpu_addr),
        .two_banks(two_banks), .crtc_ma(crtc_ma), .crtc_ra(crtc_ra),
        .offset_select_low(offset_select_low),
        .offset_select_high(offset_select_high), .pix_mode(pix_mode),
        .ram_data(ram_data), .ram_addr(ram_addr), .ras_n(ras_n),
        .cas_lo_n(cas_lo_n), .cas_hi_n(cas_hi_n), .cpu_slot(cpu_slot),
        .cpu_ram_sel(cpu_ram_sel), .text_mode(text_mode),
        .char_code(char_code), .char_strobe(char_strobe),
        .pix_bits(pix_bits), .pix_valid(pix_valid), .pix_ready(pix_ready),
        .crtc_stall(crtc_stall), .clk8(clk8), .clk4(clk4), .clk2(clk2),
        .char_clk(char_clk));
    svda_dram_model i_svda_dram_model (.ram_addr(ram_addr), .ras_n(ras_n),
        .cas_lo_n(cas_lo_n), .cas_hi_n(cas_hi_n), .ram_data(ram_data));

    always #4 clk = ~clk;

    function automatic logic [14:0] disp_addr();
        logic [15:0] off;
        logic [3:0]  adj;
        case ({offset_select_high, offset_select_low})
            2'b00: off = BYTE_OFF_16K;
            2'b01: off = BYTE_OFF_8K;
            2'b10: off = BYTE_OFF_20K;
            default: off = BYTE_OFF_10K;
        endcase
        adj = crtc_ma[11:8] + (crtc_ma[12] ? off[14:11] : 4'h0);
        if (crtc_ma[13])
            return {1'b1, 4'hf, crtc_ma[9:0]};
        return {adj, crtc_ma[7:0], crtc_ra};
    endfunction

    function automatic logic [7:0] pat(input logic [14:0] a);
        return a[7:0] ^ {a[14:8], 1'b1};
    endfunction

    task automatic report_and_stop();
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Inputs change only at the start of a display slot, held for the pair
    task automatic pair(input logic text, input int rdy);
        @(negedge clk);
        while (cpu_slot !== 1'b1) @(negedge clk);
        while (cpu_slot !== 1'b0) @(negedge clk);
        cpu_addr = 16'($random(seed));
        crtc_ma = 14'($random(seed));
        crtc_ma[13] = text;
        crtc_ra = 3'($random(seed));
        {offset_select_high, offset_select_low} = 2'($random(seed));
        two_banks = 1'($random(seed));
        pix_ready = (rdy == 2) ? (2'($random(seed)) != 2'b00) : rdy[0];
        #1;
        `CHK(cpu_ram_sel, ~cpu_addr[15])
        `CHK(text_mode, text)
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end

    // Monitor samples pre-edge values of registered outputs
    always @(posedge clk) begin
        if (reset) begin
            last_ras = 1;
            last_cas = 1;
            last_cs = 0;
            got_cas = 0;
            slot_ok = 0;
        end else begin
            ea = cpu_slot ? cpu_addr[14:0] : disp_addr();
            hi = !two_banks || ea[14];
            // Display byte lands while the processor slot is showing
            da = disp_addr();
            dh = !two_banks || da[14];
            if (last_ras && ras_n === 1'b0)
                row = ram_addr;
            if (last_cas && !(cas_lo_n && cas_hi_n)) begin
                got_cas = 1;
                `CHK({ram_addr, row}, ea[13:0])
                `CHK({cas_lo_n, cas_hi_n}, hi ? 2'b10 : 2'b01)
            end
            slot_len++;
            if (cpu_slot !== last_cs) begin
                if (slot_ok)
                    `CHK(slot_len, SLOT_CYC)
                `CHK(got_cas, exp_acc)
                slot_ok = 1;
                slot_len = 0;
                got_cas = 0;
            end else begin
                exp_acc = !cpu_slot || !cpu_addr[15];
            end
            // slot_len now equals the phase of the sampled outputs
            e4 = (slot_len < QTR_2);
            e8 = (slot_len < QTR_1) || (!e4 && (slot_len < QTR_3));
            er = !((slot_len >= RAS_PH) && e4);
            ec = slot_len ? (((slot_len - 1) < QTR_2) ^ cpu_slot) : !cpu_slot;
            if (slot_ok) begin
                `CHK({clk8, clk4, clk2}, {e8, e4, cpu_slot})
                `CHK(ras_n, er)
                `CHK(char_clk, ec)
            end
            if (!last_cs && cpu_slot && !crtc_ma[13] && chk_pix)
                q.push_back(pat({dh, da[13:0]}));
            if (char_strobe === 1'b1)
                `CHK(char_code, pat({dh, da[13:0]}))
            if (pix_valid === 1'b1 && pix_ready && chk_pix) begin
                w = 1 << int'(pix_mode);
                if (npix == 0) begin
                    `CHK(q.size() > 0, 1'b1)
                    cur = q.pop_front();
                    npix = 8 / w;
                end
                `CHK(pix_bits & 4'((1 << w) - 1), 4'(cur >> (8 - w)))
                cur = cur << w;
                npix--;
            end
            last_ras = ras_n;
            last_cas = cas_lo_n && cas_hi_n;
            last_cs = cpu_slot;
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk) reset = 0;
        for (m = 0; m < 3; m++) begin
            pix_mode = svda_pix_mode_t'(m);
            for (i = 0; i < 16; i++) begin
                pair(i % 4 == 3, 2);
                // Wrap with offset selects 0-2 first; select 3 falls on a text pair
                if (i < 4) begin
                    crtc_ma[12] = 1'b1;
                    {offset_select_high, offset_select_low} = 2'(i);
                end
            end
            repeat (4) pair(1, 1);
            `CHK(q.size(), 0)
        end
        // Receiver stalls: buffer fills and shows back-pressure
        chk_pix = 0;
        repeat (5) pair(0, 0);
        @(negedge clk);
        `CHK(crtc_stall, 1'b1)
        repeat (4) pair(1, 1);
        `CHK(pix_valid, 1'b0)
        q.delete();
        npix = 0;
        chk_pix = 1;
        repeat (6) pair(0, 2);
        report_and_stop();
    end
endmodule
